// ### hw/csg_clock_gen.sv
// Clock source control, frequency select and peripheral clock gating
`timescale 1ns/10ps
// What this block does
// - Fast oscillator runs one of five boot frequencies
// - CPU runs from fast oscillator after reset
// - Stop instruction halts the fast oscillator
// - Software overrides boot frequency via select register
// - Slow oscillator never clocks the CPU
// - Slow oscillator runs if watchdog or supply set
// - Watchdog-only slow oscillator stops in standby unless option bit 0 set
// - Enable register resets zero, bit and byte writes
// - Bit 7 gates and resets the interval timer
// - Bit 6 gates the real-time output controller
// - Bit 5 gates and resets the converter
// - Bit 2 gates and resets the serial unit
// - Bit 0 gates and resets the timer array
// - Select codes one to five, reset copies boot
// - Switch: three old clocks, three new wait
module csg_clock_gen
    import csg_pkg::*;
#(
    parameter bit HAS_RTO = 1'b1                           // Real-time output present
)(
    input  wire logic                         ref_clk_i,   // 100 MHz block clock
    input  wire logic                         rst_n_i,     // Sync reset, active low
    input  wire csg_sfr_req_s                 sfr_i,       // Register port access
    output logic      [7:0]                   sfr_rdata_o, // Read data, one cycle later
    input  wire logic [7:0]                   opt_freq_i,  // Frequency option byte
    input  wire logic [7:0]                   opt_wdt_i,   // Watchdog option byte
    input  wire logic                         halt_exec_i, // CPU executes halt, pulse
    input  wire logic                         stop_exec_i, // CPU executes stop, pulse
    input  wire logic                         wake_i,      // Standby release, pulse
    output logic                              fast_osc_run_o,  // Fast oscillator on
    output logic      [2:0]                   fast_osc_code_o, // Fast oscillator code
    output logic                              cpu_clk_wait_o,  // CPU clock held
    output logic                              slow_osc_run_o,  // Slow oscillator on
    output csg_gate_s [CSG_NUM_GATES-1:0]     gate_o       // Per-peripheral gating
);

    localparam logic [7:0] GATE_EN_MASK = HAS_RTO ? CSG_GATE_EN_USED : CSG_GATE_EN_NO_RTO;

    logic [7:0] gate_en_ff;
    logic [7:0] slow_ctl_ff;
    logic [2:0] freq_sel_ff;
    logic [7:0] opt_wdt_ff;
    logic [7:0] rdata_ff;
    logic       fast_run_ff;
    logic       slow_run_ff;
    csg_pwr_e   pwr_ff;
    logic [2:0] boot_code;
    logic       sw_busy;
    logic       sw_req;
    logic [7:0] wr_bits;
    logic       hit_gate;
    logic       hit_slow;
    logic       hit_freq;

    // Illegal boot codes fall back to the fastest setting
    assign boot_code = csg_code_legal(opt_freq_i[2:0]) ? opt_freq_i[2:0] : CSG_FREQ_20M;
    assign hit_gate  = (sfr_i.addr == CSG_ADDR_GATE_EN);
    assign hit_slow  = (sfr_i.addr == CSG_ADDR_SLOW_CTL);
    assign hit_freq  = (sfr_i.addr == CSG_ADDR_FREQ_SEL);
    assign wr_bits   = sfr_i.data & sfr_i.mask;

    // Prohibited codes and writes during a switch are dropped
    assign sw_req = sfr_i.wr && hit_freq && (sfr_i.mask == 8'hFF)
                    && csg_code_legal(sfr_i.data[2:0]) && !sw_busy;

    // Peripheral enable register, merge keeps unmasked bits
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            gate_en_ff <= CSG_GATE_EN_RST;
        end else if (sfr_i.wr && hit_gate) begin
            gate_en_ff <= ((gate_en_ff & ~sfr_i.mask) | wr_bits) & GATE_EN_MASK;
        end
    end

    // Slow clock supply control, byte writes only
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            slow_ctl_ff <= CSG_SLOW_CTL_RST;
        end else if (sfr_i.wr && hit_slow && (sfr_i.mask == 8'hFF)) begin
            slow_ctl_ff <= sfr_i.data & CSG_SLOW_CTL_USED;
        end
    end

    // Frequency select mirrors the boot field until software writes it
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            freq_sel_ff <= boot_code;
        end else if (sw_req) begin
            freq_sel_ff <= sfr_i.data[2:0];
        end
    end

    // Watchdog option byte caught while reset is held
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            opt_wdt_ff <= opt_wdt_i;
        end
    end

    // Read port; unmapped addresses return zero
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rdata_ff <= 8'h00;
        end else if (sfr_i.rd) begin
            if (hit_gate) begin
                rdata_ff <= gate_en_ff;
            end else if (hit_slow) begin
                rdata_ff <= slow_ctl_ff;
            end else if (hit_freq) begin
                rdata_ff <= {5'h00, freq_sel_ff};
            end else begin
                rdata_ff <= 8'h00;
            end
        end
    end

    // Standby tracking; fast oscillator only dies in stop
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pwr_ff      <= CSG_RUN;
            fast_run_ff <= 1'b1;
        end else begin
            case (pwr_ff)
                CSG_RUN: begin
                    if (stop_exec_i) begin
                        pwr_ff      <= CSG_STOP;
                        fast_run_ff <= 1'b0;
                    end else if (halt_exec_i) begin
                        pwr_ff <= CSG_HALT;
                    end
                end
                CSG_HALT, CSG_STOP: begin
                    if (wake_i) begin
                        pwr_ff      <= CSG_RUN;
                        fast_run_ff <= 1'b1;
                    end
                end
                default: pwr_ff <= CSG_RUN;
            endcase
        end
    end

    // Slow oscillator demand; it is never offered to the CPU
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            slow_run_ff <= 1'b0;
        end else begin
            slow_run_ff <= (opt_wdt_ff[CSG_BIT_WDT_EN] || slow_ctl_ff[CSG_BIT_SUPPLY])
                && !((pwr_ff != CSG_RUN) && opt_wdt_ff[CSG_BIT_WDT_EN]
                     && !slow_ctl_ff[CSG_BIT_SUPPLY] && !opt_wdt_ff[CSG_BIT_WDT_STBY]);
        end
    end

    // Switch sequencer drives the oscillator code and CPU clock wait
    csg_freq_switch u_freq_switch (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .boot_code_i (boot_code),
        .req_i       (sw_req),
        .code_i      (sfr_i.data[2:0]),
        .code_o      (fast_osc_code_o),
        .wait_o      (cpu_clk_wait_o),
        .busy_o      (sw_busy)
    );

    // Enables are flops, so a peripheral clock never sees a runt pulse
    generate
        for (genvar g = 0; g < CSG_NUM_GATES; g++) begin : g_gate
            assign gate_o[g].clk_en   = gate_en_ff[CSG_GATE_POS[g]];
            assign gate_o[g].rst_n    = gate_en_ff[CSG_GATE_POS[g]];
            assign gate_o[g].wr_allow = gate_en_ff[CSG_GATE_POS[g]];
        end
    endgenerate

    assign sfr_rdata_o    = rdata_ff;
    assign fast_osc_run_o = fast_run_ff;
    assign slow_osc_run_o = slow_run_ff;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_gate_reset_zero: assert property (@(posedge ref_clk_i) disable iff (1'b0)
        !rst_n_i |=> (gate_en_ff == CSG_GATE_EN_RST))
        else $error("enable register not cleared by reset");
    a_gate_bit_write: assert property (
        (sfr_i.wr && hit_gate) |=> ((gate_en_ff & ~$past(sfr_i.mask))
            == ($past(gate_en_ff) & ~$past(sfr_i.mask))))
        else $error("unmasked enable bit changed");
    a_unused_bits_zero: assert property (
        (gate_en_ff & ~GATE_EN_MASK) == 8'h00)
        else $error("unused enable bit set");
    a_itmr_gate: assert property (
        (gate_o[0].clk_en == gate_en_ff[CSG_BIT_ITMR])
        && (gate_o[0].rst_n == gate_en_ff[CSG_BIT_ITMR]))
        else $error("interval timer gate mismatch");
    a_tmrarr_gate: assert property (
        (sfr_i.wr && hit_gate && sfr_i.mask[CSG_BIT_TMRARR])
        |=> (gate_o[4].wr_allow == $past(sfr_i.data[CSG_BIT_TMRARR])))
        else $error("timer array gate did not follow write");
    a_fast_osc_stop: assert property (
        (pwr_ff == CSG_RUN && stop_exec_i) |=> !fast_osc_run_o throughout (!wake_i) [*1])
        else $error("fast oscillator still running after stop");
    a_slow_osc_need: assert property (
        (slow_ctl_ff[CSG_BIT_SUPPLY] && $stable(slow_ctl_ff)) |=> slow_osc_run_o)
        else $error("slow oscillator off while supply set");
    a_slow_osc_stby: assert property (
        ((pwr_ff != CSG_RUN) && opt_wdt_ff[CSG_BIT_WDT_EN] && !slow_ctl_ff[CSG_BIT_SUPPLY]
         && !opt_wdt_ff[CSG_BIT_WDT_STBY]
         && $stable(pwr_ff)) |=> !slow_osc_run_o)
        else $error("slow oscillator runs in standby");
    a_hoco_reset_boot: assert property (@(posedge ref_clk_i) disable iff (1'b0)
        !rst_n_i |=> (freq_sel_ff == $past(boot_code)))
        else $error("select register not loaded from boot field");
    a_fast_run_reset: assert property (@(posedge ref_clk_i) disable iff (1'b0)
        !rst_n_i |=> fast_osc_run_o)
        else $error("fast oscillator not running after reset");

endmodule // csg_clock_gen

// ### hw/csg_freq_switch.sv
// Fast oscillator frequency switch sequencer
`timescale 1ns/10ps
module csg_freq_switch
    import csg_pkg::*;
(
    input  wire logic       ref_clk_i,   // Block clock
    input  wire logic       rst_n_i,     // Sync reset, active low
    input  wire logic [2:0] boot_code_i, // Code applied at reset
    input  wire logic       req_i,       // Switch request pulse
    input  wire logic [2:0] code_i,      // Requested code
    output logic      [2:0] code_o,      // Code driven to oscillator
    output logic            wait_o,      // Clock wait at new frequency
    output logic            busy_o       // Transition in progress
);

    csg_sw_e    state_ff;
    logic [1:0] cnt_ff;
    logic [2:0] pend_ff;

    // Old clocks run out, then the new code is driven at once while the CPU clock waits
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_ff <= CSG_SW_IDLE;
            cnt_ff   <= 2'h0;
            pend_ff  <= CSG_FREQ_20M;
            code_o   <= boot_code_i;
            wait_o   <= 1'b0;
        end else begin
            case (state_ff)
                CSG_SW_IDLE: begin
                    if (req_i) begin
                        state_ff <= CSG_SW_OLD;
                        cnt_ff   <= 2'h1;
                        pend_ff  <= code_i;
                    end
                end
                CSG_SW_OLD: begin
                    if (cnt_ff == CSG_SW_OLD_CLKS) begin
                        state_ff <= CSG_SW_NEW;
                        cnt_ff   <= 2'h1;
                        code_o   <= pend_ff;
                        wait_o   <= 1'b1;
                    end else begin
                        cnt_ff <= cnt_ff + 2'h1;
                    end
                end
                CSG_SW_NEW: begin
                    if (cnt_ff == CSG_SW_NEW_CLKS) begin
                        state_ff <= CSG_SW_IDLE;
                        wait_o   <= 1'b0;
                    end else begin
                        cnt_ff <= cnt_ff + 2'h1;
                    end
                end
                default: state_ff <= CSG_SW_IDLE;
            endcase
        end
    end

    // Wait is a flop so the top output needs no decode after the state register
    assign busy_o = (state_ff != CSG_SW_IDLE);

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_old_phase;
        !wait_o [*3];
    endsequence
    sequence s_new_phase;
        wait_o [*3] ##1 !wait_o;
    endsequence

    a_switch_old_hold: assert property (
        (req_i && !busy_o) |=> $stable(code_o) [*3] ##1 (code_o == $past(code_i, 4)))
        else $error("code changed before three old clocks");
    a_switch_wait_len: assert property (
        (req_i && !busy_o) |=> s_old_phase ##1 s_new_phase)
        else $error("new-frequency wait not three clocks");

endmodule // csg_freq_switch

// ### hw/csg_pkg.sv
// Shared constants, types and helpers for the clock source and gating block
package csg_pkg;

    // Register byte addresses on the special function register port
    localparam logic [19:0] CSG_ADDR_GATE_EN  = 20'hF00F0;
    localparam logic [19:0] CSG_ADDR_SLOW_CTL = 20'hF00F3;
    localparam logic [19:0] CSG_ADDR_FREQ_SEL = 20'hF00A8;

    // Reset values
    localparam logic [7:0]  CSG_GATE_EN_RST  = 8'h00;
    localparam logic [7:0]  CSG_SLOW_CTL_RST = 8'h00;

    // Peripheral clock gate enable bit positions
    localparam int          CSG_BIT_ITMR     = 7;
    localparam int          CSG_BIT_RTO      = 6;
    localparam int          CSG_BIT_ADC      = 5;
    localparam int          CSG_BIT_SERIAL   = 2;
    localparam int          CSG_BIT_TMRARR   = 0;
    localparam int          CSG_NUM_GATES    = 5;
    localparam int          CSG_GATE_POS [0:CSG_NUM_GATES-1] =
        '{CSG_BIT_ITMR, CSG_BIT_RTO, CSG_BIT_ADC, CSG_BIT_SERIAL, CSG_BIT_TMRARR};
    localparam logic [7:0]  CSG_GATE_EN_USED   = 8'hE5;
    localparam logic [7:0]  CSG_GATE_EN_NO_RTO = 8'hA5;

    // Slow clock supply bit and option byte fields
    localparam int          CSG_BIT_SUPPLY   = 4;
    localparam int          CSG_BIT_WDT_EN   = 4;
    localparam int          CSG_BIT_WDT_STBY = 0;
    localparam logic [7:0]  CSG_SLOW_CTL_USED = 8'h10;

    // Fast oscillator frequency codes
    localparam logic [2:0]  CSG_FREQ_20M     = 3'h1;
    localparam logic [2:0]  CSG_FREQ_10M     = 3'h2;
    localparam logic [2:0]  CSG_FREQ_5M      = 3'h3;
    localparam logic [2:0]  CSG_FREQ_2M5     = 3'h4;
    localparam logic [2:0]  CSG_FREQ_1M25    = 3'h5;

    // Frequency switch transition, in clocks at old and at new frequency
    localparam logic [1:0]  CSG_SW_OLD_CLKS  = 2'h3;
    localparam logic [1:0]  CSG_SW_NEW_CLKS  = 2'h3;

    typedef enum {CSG_RUN, CSG_HALT, CSG_STOP} csg_pwr_e;
    typedef enum {CSG_SW_IDLE, CSG_SW_OLD, CSG_SW_NEW} csg_sw_e;

    // One register port access
    typedef struct packed {
        logic [19:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  mask;
        logic [7:0]  data;
    } csg_sfr_req_s;

    // Per-peripheral gating bundle
    typedef struct packed {
        logic clk_en;
        logic rst_n;
        logic wr_allow;
    } csg_gate_s;

    // Only the five listed codes are legal
    function automatic logic csg_code_legal(input logic [2:0] code);
        return (code >= CSG_FREQ_20M) && (code <= CSG_FREQ_1M25);
    endfunction

endpackage

// ### sim/csg_periph_model.sv
// Behavioural model of the gated peripherals on the far side of the clock block
`timescale 1ns/10ps
module csg_periph_model
    import csg_pkg::*;
(
    input  wire logic                     ref_clk_i, // Block clock
    input  wire csg_gate_s [CSG_NUM_GATES-1:0] gate_i, // Gating bundle per peripheral
    input  wire logic [CSG_NUM_GATES-1:0] wr_i,      // Register write strobe per peripheral
    input  wire logic [7:0]               data_i,    // Register write data
    output logic [CSG_NUM_GATES-1:0][7:0] regs_o     // One setting register per peripheral
);
    // Each peripheral takes a setting only while clocked, writable and out of reset, and clears in reset
    always_ff @(posedge ref_clk_i) begin
        for (int k = 0; k < CSG_NUM_GATES; k++) begin
            if (!gate_i[k].rst_n) begin
                regs_o[k] <= 8'h00;
            end else if (gate_i[k].clk_en && gate_i[k].wr_allow && wr_i[k]) begin
                regs_o[k] <= data_i;
            end
        end
    end
endmodule // csg_periph_model

// ### sim/testbench.sv
// Self-checking bench for the clock source and gating block
`timescale 1ns/10ps
module testbench;
    import csg_pkg::*;
    logic                     ref_clk_i;
    logic                     rst_n_i;
    csg_sfr_req_s             sfr;
    logic [7:0]               rdata;
    logic [7:0]               opt_freq;
    logic [7:0]               opt_wdt;
    logic [2:0]               pwr;       // Halt, stop, wake pulses
    logic                     fast_run;
    logic [2:0]               fast_code;
    logic                     clk_wait;
    logic                     slow_run;
    csg_gate_s [CSG_NUM_GATES-1:0] gate;
    logic [CSG_NUM_GATES-1:0] pw;
    logic [7:0]               pdata;
    logic [CSG_NUM_GATES-1:0][7:0] pregs;
    logic [7:0]               en_exp;
    logic [2:0]               cur_code;
    int                       err_count;
    int                       n_checks;

    csg_clock_gen DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sfr_i(sfr),
        .sfr_rdata_o(rdata), .opt_freq_i(opt_freq), .opt_wdt_i(opt_wdt),
        .halt_exec_i(pwr[2]), .stop_exec_i(pwr[1]), .wake_i(pwr[0]),
        .fast_osc_run_o(fast_run), .fast_osc_code_o(fast_code),
        .cpu_clk_wait_o(clk_wait), .slow_osc_run_o(slow_run), .gate_o(gate));

    csg_periph_model PERIPH (.ref_clk_i(ref_clk_i), .gate_i(gate), .wr_i(pw),
        .data_i(pdata), .regs_o(pregs));

    // Free-running 100 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // All three gate controls follow the enable bit
    task automatic chk_gates(input logic [7:0] e);
        for (int i = 0; i < CSG_NUM_GATES; i++) begin
            chk8({5'h00, gate[i]}, {5'h00, {3{e[CSG_GATE_POS[i]]}}});
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Options are held stable across the whole reset
    task automatic do_reset(input logic [7:0] f, input logic [7:0] w);
        @(negedge ref_clk_i);
        rst_n_i = 1'b0;
        opt_freq = f;
        opt_wdt = w;
        repeat (12) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
    endtask

    // One idle cycle between accesses keeps each strobe a single pulse
    task automatic sfr_wr(input logic [19:0] a, input logic [7:0] m, input logic [7:0] d);
        @(negedge ref_clk_i);
        sfr = '{addr: a, wr: 1'b1, rd: 1'b0, mask: m, data: d};
        @(negedge ref_clk_i);
        sfr = '0;
    endtask

    task automatic sfr_rd(input logic [19:0] a, input logic [7:0] exp);
        @(negedge ref_clk_i);
        sfr = '{addr: a, wr: 1'b0, rd: 1'b1, mask: 8'h00, data: 8'h00};
        @(negedge ref_clk_i);
        sfr = '0;
        chk8(rdata, exp);
    endtask

    // Pulse then allow the registered outputs to settle
    task automatic pulse(input int k);
        @(negedge ref_clk_i);
        pwr[k] = 1'b1;
        @(negedge ref_clk_i);
        pwr = '0;
        repeat (2) @(negedge ref_clk_i);
    endtask

    task automatic pwrite(input int k, input logic [7:0] d);
        @(negedge ref_clk_i);
        pw[k] = 1'b1;
        pdata = d;
        @(negedge ref_clk_i);
        pw = '0;
    endtask

    // Old code for three cycles, then new code with a three-cycle wait
    task automatic freq_sw(input logic [2:0] c);
        sfr_wr(CSG_ADDR_FREQ_SEL, 8'hFF, {5'h00, c});
        for (int k = 1; k < 8; k++) begin
            chk8({5'h00, fast_code}, {5'h00, (k < 4) ? cur_code : c});
            chk8({7'h00, clk_wait}, {7'h00, (k >= 4 && k < 7)});
            @(negedge ref_clk_i);
        end
        cur_code = c;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_count++;
        finish_test();
    end

    initial begin
        err_count = 0;
        n_checks = 0;
        rst_n_i = 1'b0;
        sfr = '0;
        pwr = '0;
        pw = '0;
        pdata = 8'h00;
        opt_freq = 8'hFB;
        opt_wdt = 8'h10;
        cur_code = 3'h3;
        en_exp = 8'h00;
        do_reset(8'hFB, 8'h10);
        sfr_rd(CSG_ADDR_GATE_EN, CSG_GATE_EN_RST);
        sfr_rd(CSG_ADDR_FREQ_SEL, 8'h03);
        sfr_rd(CSG_ADDR_SLOW_CTL, CSG_SLOW_CTL_RST);
        chk8({7'h00, fast_run}, 8'h01);
        chk8({5'h00, fast_code}, 8'h03);
        chk8({7'h00, slow_run}, 8'h01);
        chk_gates(8'h00);
        // Enable one peripheral at a time by bit writes, then configure it
        for (int i = 0; i < CSG_NUM_GATES; i++) begin
            en_exp[CSG_GATE_POS[i]] = 1'b1;
            sfr_wr(CSG_ADDR_GATE_EN, 8'h01 << CSG_GATE_POS[i], 8'hFF);
            chk_gates(en_exp);
            pwrite(i, 8'h5A ^ 8'(i));
            chk8(pregs[i], 8'h5A ^ 8'(i));
        end
        sfr_wr(CSG_ADDR_GATE_EN, 8'hFF, 8'hFF);
        sfr_rd(CSG_ADDR_GATE_EN, CSG_GATE_EN_USED);
        sfr_wr(CSG_ADDR_GATE_EN, 8'hFF, 8'h00);
        chk_gates(8'h00);
        for (int i = 0; i < CSG_NUM_GATES; i++) begin
            pwrite(i, 8'hC3);
            chk8(pregs[i], 8'h00);
        end
        // Every legal code, then the prohibited ones
        for (int c = 1; c < 6; c++) begin
            freq_sw(3'(c));
            sfr_rd(CSG_ADDR_FREQ_SEL, 8'(c));
        end
        for (int c = 0; c < 3; c++) begin
            sfr_wr(CSG_ADDR_FREQ_SEL, 8'hFF, (c == 0) ? 8'h00 : 8'(c + 5));
            repeat (7) @(negedge ref_clk_i);
            sfr_rd(CSG_ADDR_FREQ_SEL, 8'h05);
            chk8({5'h00, fast_code}, 8'h05);
        end
        // Standby with watchdog only, then with supply bit set
        pulse(2);
        chk8({6'h00, slow_run, fast_run}, 8'h01);
        pulse(0);
        chk8({7'h00, slow_run}, 8'h01);
        sfr_wr(CSG_ADDR_SLOW_CTL, 8'hFF, 8'h10);
        sfr_rd(CSG_ADDR_SLOW_CTL, 8'h10);
        pulse(2);
        chk8({7'h00, slow_run}, 8'h01);
        pulse(0);
        pulse(1);
        chk8({7'h00, fast_run}, 8'h00);
        pulse(0);
        chk8({7'h00, fast_run}, 8'h01);
        // Second reset with watchdog off clears the enables and supply bit, and reloads the boot code
        sfr_wr(CSG_ADDR_GATE_EN, 8'hFF, 8'hE5);
        do_reset(8'hFD, 8'h00);
        cur_code = 3'h5;
        sfr_rd(CSG_ADDR_GATE_EN, 8'h00);
        sfr_rd(CSG_ADDR_FREQ_SEL, 8'h05);
        chk8({6'h00, slow_run, fast_run}, 8'h01);
        sfr_wr(CSG_ADDR_SLOW_CTL, 8'hFF, 8'h10);
        repeat (2) @(negedge ref_clk_i);
        chk8({7'h00, slow_run}, 8'h01);
        sfr_rd(20'hF00F1, 8'h00);
        finish_test();
    end
endmodule // testbench
